// [rtl/wtc_top.sv]
// Contract
// - Writing one to the enable bit turns the watchdog on; zero turns it off.
// - A zero written to enable is ignored unless change-enable is currently set.
// - In safety level 2 the watchdog keeps running whatever software writes.
// - Prescaler code selects 16K up to 2,048K oscillator cycles of time-out.
// - Level 1 comes up disabled; enabling needs no timed sequence.
// - Level 1 changes prescaler or disables only through the timed sequence.
// - In level 2 the enable bit always reads one.
// - Level 2 second write within four cycles sets prescaler; its enable value is ignored.
// - The fuse picks the level: unprogrammed level 1, programmed level 2 always on.
// - Hardware clears change-enable four clock cycles after it was written one.
// - Restart, disable and reset clear the counter; expiry resets the device.
// - A time-out yields a reset pulse one system clock cycle long.
`timescale 1ns/10ps
`default_nettype none

module wtc_top
    import wtc_pkg::*;
#(
    parameter int BASE_TICKS = WTC_BASE_TICKS,
    parameter int WINDOW_CYC = WTC_WINDOW_CYC
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic [WTC_ADDR_W-1:0] i_addr,
    input  wire logic [WTC_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    input  wire logic                  i_restart,
    input  wire logic                  i_wd_osc,
    input  wire logic                  i_fuse_always_on,
    output logic      [WTC_DATA_W-1:0] o_rdata,
    output logic                       o_wd_reset,
    output logic                       o_wd_enabled,
    output logic                       o_level2
);

    // The synchroniser shows the fuse one edge after its last stage fills, so the
    // level is taken one count later than the stage count alone would give.
    localparam int SETTLE_LAST = WTC_FUSE_SETTLE + 1;
    localparam int FW          = $clog2(SETTLE_LAST + 1);

    typedef enum logic [2:0] {
        WTC_ST_SETTLE = 3'b001,
        WTC_ST_LEVEL1 = 3'b010,
        WTC_ST_LEVEL2 = 3'b100
    } wtc_mode_t;

    wtc_mode_t                  mode_r;
    logic [FW-1:0]              settle_r;
    logic                       en_r;
    logic [WTC_PSC_W-1:0]       psc_r;
    logic [WTC_CNT_W-1:0]       cnt_r;
    logic [WTC_CNT_W-1:0]       limit;
    logic                       wd_reset_r;
    logic                       tmo_seen_r;
    logic [WTC_DATA_W-1:0]      rdata_r;
    logic                       level2_r;

    logic                       osc_level;
    logic                       osc_rise;
    logic                       fuse_level;
    logic                       win_open;

    logic                       wr_ctrl;
    logic                       wr_ce;
    logic                       wr_en;
    logic [WTC_PSC_W-1:0]       wr_psc;
    logic                       win_start;
    logic                       win_commit;
    logic                       expire;
    logic                       at_limit;

    wtc_sync u_osc_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_wd_osc),
        .o_level (osc_level),
        .o_rise  (osc_rise)
    );

    wtc_sync u_fuse_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_fuse_always_on),
        .o_level (fuse_level),
        .o_rise  ()
    );

    // Decode of a write to watchdog_control.
    assign wr_ctrl    = i_wr && (i_addr == WTC_CTRL_OFF);
    assign wr_ce      = i_wdata[WTC_CE_BIT];
    assign wr_en      = i_wdata[WTC_EN_BIT];
    assign wr_psc     = i_wdata[WTC_PSC_LSB +: WTC_PSC_W];

    // Any write of one to change-enable (re)starts the window.
    assign win_start  = wr_ctrl && wr_ce;
    // A write with change-enable clear inside the window commits and closes it.
    assign win_commit = wr_ctrl && !wr_ce && win_open;

    wtc_window #(
        .CYCLES (WINDOW_CYC)
    ) u_window (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_open  (win_start),
        .i_close (win_commit),
        .o_open  (win_open)
    );

    // The fuse is sampled once the synchroniser has settled after reset.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r   <= WTC_ST_SETTLE;
            settle_r <= '0;
        end else begin
            case (mode_r)
                WTC_ST_SETTLE: begin
                    if (settle_r == FW'(SETTLE_LAST)) begin
                        mode_r <= fuse_level ? WTC_ST_LEVEL2 : WTC_ST_LEVEL1;
                    end else begin
                        settle_r <= settle_r + FW'(1);
                    end
                end
                WTC_ST_LEVEL1: begin
                    mode_r <= WTC_ST_LEVEL1;
                end
                WTC_ST_LEVEL2: begin
                    mode_r <= WTC_ST_LEVEL2;
                end
                default: begin
                    mode_r <= WTC_ST_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            level2_r <= 1'b0;
        end else begin
            level2_r <= (mode_r == WTC_ST_LEVEL2);
        end
    end

    // Enable bit: set freely, cleared only inside an open window, locked on in level 2.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            en_r <= WTC_CTRL_RESET[WTC_EN_BIT];
        end else if (mode_r == WTC_ST_LEVEL2) begin
            en_r <= 1'b1;
        end else if (wr_ctrl) begin
            if (wr_en) begin
                en_r <= 1'b1;
            end else if (win_open) begin
                en_r <= 1'b0;
            end
        end
    end

    // Prescaler changes only on the committing write of the timed sequence.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            psc_r <= WTC_CTRL_RESET[WTC_PSC_LSB +: WTC_PSC_W];
        end else if (win_commit) begin
            psc_r <= wr_psc;
        end
    end

    // Time-out length doubles with each prescaler step.
    assign limit    = WTC_CNT_W'(BASE_TICKS) << psc_r;
    // A count already past a newly shortened period expires on the next tick.
    assign at_limit = (cnt_r >= limit - WTC_CNT_W'(1));
    assign expire   = en_r && osc_rise && !i_restart && at_limit;

    // Counter advances once per watchdog-oscillator cycle while enabled.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (!en_r || i_restart || expire) begin
            cnt_r <= '0;
        end else if (osc_rise) begin
            cnt_r <= cnt_r + WTC_CNT_W'(1);
        end
    end

    // One-cycle reset request on expiry.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wd_reset_r <= 1'b0;
        end else begin
            wd_reset_r <= expire;
        end
    end

    // Sticky record of a time-out, cleared by reading the status register.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tmo_seen_r <= 1'b0;
        end else if (expire) begin
            tmo_seen_r <= 1'b1;
        end else if (i_rd && (i_addr == WTC_STAT_OFF)) begin
            tmo_seen_r <= 1'b0;
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= '0;
        end else if (i_rd) begin
            case (i_addr)
                WTC_CTRL_OFF: begin
                    rdata_r                             <= '0;
                    rdata_r[WTC_CE_BIT]                 <= win_open;
                    rdata_r[WTC_EN_BIT]                 <= en_r;
                    rdata_r[WTC_PSC_LSB +: WTC_PSC_W]   <= psc_r;
                end
                WTC_STAT_OFF: begin
                    rdata_r                     <= '0;
                    rdata_r[WTC_ST_OSC_BIT]     <= osc_level;
                    rdata_r[WTC_ST_LVL2_BIT]    <= level2_r;
                    rdata_r[WTC_ST_WIN_BIT]     <= win_open;
                    rdata_r[WTC_ST_FUSE_BIT]    <= (mode_r != WTC_ST_SETTLE);
                    rdata_r[WTC_ST_TMO_BIT]     <= tmo_seen_r || expire;
                end
                default: begin
                    rdata_r <= '0;
                end
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign o_rdata      = rdata_r;
    assign o_wd_reset   = wd_reset_r;
    assign o_wd_enabled = en_r;
    assign o_level2     = level2_r;

endmodule // wtc_top

`default_nettype wire

// [inc/wtc_pkg.sv]
package wtc_pkg;

    // Register map of the watchdog control block, byte-addressed 8-bit registers.
    localparam logic [7:0] WTC_CTRL_OFF      = 8'h00;
    localparam logic [7:0] WTC_STAT_OFF      = 8'h01;
    localparam int         WTC_ADDR_W        = 8;
    localparam int         WTC_DATA_W        = 8;

    // Field positions of watchdog_control.
    localparam int         WTC_CE_BIT        = 4;
    localparam int         WTC_EN_BIT        = 3;
    localparam int         WTC_PSC_LSB       = 0;
    localparam int         WTC_PSC_W         = 3;
    localparam logic [7:0] WTC_CTRL_RESET    = 8'h00;

    // Field positions of the status register.
    localparam int         WTC_ST_OSC_BIT    = 0;
    localparam int         WTC_ST_LVL2_BIT   = 1;
    localparam int         WTC_ST_WIN_BIT    = 2;
    localparam int         WTC_ST_FUSE_BIT   = 3;
    localparam int         WTC_ST_TMO_BIT    = 4;

    // Timing counts in system clock cycles (10 MHz, 100 ns period).
    localparam int         WTC_CLK_PERIOD_NS = 100;
    localparam int         WTC_WINDOW_CYC    = 4;
    localparam int         WTC_RST_PULSE_CYC = 1;
    localparam int         WTC_FUSE_SETTLE   = 3;

    // Time-out base in watchdog-oscillator cycles for prescaler code 000.
    localparam int         WTC_BASE_TICKS    = 16384;
    localparam int         WTC_CNT_W         = 22;

endpackage

// [rtl/wtc_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module wtc_sync (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_async,
    output logic      o_level,
    output logic      o_rise
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;
    logic rise_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A new level counts only once the second and third stages agree.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            level_r <= 1'b0;
            rise_r  <= 1'b0;
        end else begin
            rise_r <= (s2_r == s3_r) && s3_r && !level_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    assign o_level = level_r;
    assign o_rise  = rise_r;

endmodule // wtc_sync

`default_nettype wire

// [rtl/wtc_window.sv]
`timescale 1ns/10ps
`default_nettype none

module wtc_window
    import wtc_pkg::*;
#(
    parameter int CYCLES = WTC_WINDOW_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_open,
    input  wire logic i_close,
    output logic      o_open
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_r;

    // Opening wins over closing and over the countdown.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (i_open) begin
            cnt_r <= CW'(CYCLES);
        end else if (i_close) begin
            cnt_r <= '0;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
        end
    end

    assign o_open = (cnt_r != '0);

endmodule // wtc_window

`default_nettype wire

// [sim/wtc_top_sva.sv]
`timescale 1ns/10ps
`default_nettype none

module wtc_top_sva
    import wtc_pkg::*;
#(
    parameter int BASE_TICKS = WTC_BASE_TICKS,
    parameter int WINDOW_CYC = WTC_WINDOW_CYC
) (
    input wire logic                  i_clk,
    input wire logic                  i_rst,
    input wire logic [WTC_ADDR_W-1:0] i_addr,
    input wire logic [WTC_DATA_W-1:0] i_wdata,
    input wire logic                  i_wr,
    input wire logic                  i_rd,
    input wire logic [WTC_DATA_W-1:0] o_rdata,
    input wire logic                  o_wd_reset,
    input wire logic                  o_wd_enabled,
    input wire logic                  o_level2
);
    // Cycles since the last write that set change-enable, saturating at 7.
    logic [2:0] win_age_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            win_age_r <= 3'h7;
        end else if (i_wr && i_addr == WTC_CTRL_OFF && i_wdata[WTC_CE_BIT]) begin
            win_age_r <= 3'h0;
        end else if (win_age_r != 3'h7) begin
            win_age_r <= win_age_r + 3'h1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_RSV_ZERO: assert property ($past(i_rd) |-> o_rdata[7:5] == 3'h0)
        else $error("reserved bits not zero");
    AST_RST_PULSE: assert property (o_wd_reset |=> !o_wd_reset)
        else $error("reset pulse longer than one cycle");
    AST_TMO_EN: assert property (o_wd_reset |-> $past(o_wd_enabled))
        else $error("time-out while disabled");
    AST_LVL2_EN: assert property (o_level2 |=> o_wd_enabled)
        else $error("watchdog off in level 2");
    AST_LVL2_HOLD: assert property (o_level2 |=> o_level2)
        else $error("level 2 dropped");
    AST_EN_ON_WRITE: assert property (i_wr && i_addr == WTC_CTRL_OFF && i_wdata[WTC_EN_BIT]
        && !o_level2 |=> o_wd_enabled)
        else $error("enable write not taken");
    AST_DIS_WINDOW: assert property ($fell(o_wd_enabled) |-> $past(win_age_r) < WINDOW_CYC
        && $past(i_wr) && !$past(i_wdata[WTC_EN_BIT]))
        else $error("disable outside window");
    AST_CE_CLEAR: assert property ($past(i_rd) && $past(i_addr) == WTC_CTRL_OFF
        && $past(win_age_r) >= WINDOW_CYC |-> !o_rdata[WTC_CE_BIT])
        else $error("change-enable not cleared");
    AST_LVL2_READ: assert property ($past(i_rd) && $past(i_addr) == WTC_CTRL_OFF
        && $past(o_level2) |-> o_rdata[WTC_EN_BIT])
        else $error("enable reads zero in level 2");
endmodule // wtc_top_sva

bind wtc_top wtc_top_sva #(.BASE_TICKS(BASE_TICKS), .WINDOW_CYC(WINDOW_CYC)) chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_wd_reset(o_wd_reset),
    .o_wd_enabled(o_wd_enabled), .o_level2(o_level2));

`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb;
    import wtc_pkg::*;
    localparam int BT = 4;
    logic       i_clk            = 1'b0;
    logic       i_rst            = 1'b1;
    logic [7:0] i_addr           = 8'h00;
    logic [7:0] i_wdata          = 8'h00;
    logic       i_wr             = 1'b0;
    logic       i_rd             = 1'b0;
    logic       i_restart        = 1'b0;
    logic       i_wd_osc         = 1'b0;
    logic       i_fuse_always_on = 1'b0;
    logic [7:0] o_rdata;
    logic       o_wd_reset;
    logic       o_wd_enabled;
    logic       o_level2;
    int         mismatches       = 0;
    int         n_compared       = 0;
    int         cyc              = 0;
    int         h;

    always #50 i_clk = ~i_clk;

    wtc_top #(.BASE_TICKS(BT)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_restart(i_restart), .i_wd_osc(i_wd_osc),
        .i_fuse_always_on(i_fuse_always_on), .o_rdata(o_rdata), .o_wd_reset(o_wd_reset),
        .o_wd_enabled(o_wd_enabled), .o_level2(o_level2));

    task automatic report_and_stop();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, o_rdata, e);
    endtask

    task automatic restart();
        @(posedge i_clk);
        i_restart <= 1'b1;
        @(posedge i_clk);
        i_restart <= 1'b0;
    endtask

    // Drives n oscillator periods of ten clocks; hit is the period that shows the first pulse.
    task automatic ticks(input int n, output int hit);
        hit = 0;
        for (int t = 1; t <= n; t++) begin
            for (int k = 0; k < 10; k++) begin
                @(posedge i_clk);
                i_wd_osc <= (k < 5);
                if (o_wd_reset === 1'b1 && hit == 0) hit = t;
            end
        end
    endtask

    task automatic s_reset_state();
        #1;
        chk("en", o_wd_enabled, 1'b0);
        chk("lvl2", o_level2, 1'b0);
        rd(WTC_CTRL_OFF, WTC_CTRL_RESET, "ctrl");
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00, "unmapped");
        rd(WTC_CTRL_OFF, 8'h00, "ctrl_unmapped");
    endtask

    task automatic s_free_enable();
        wr(WTC_CTRL_OFF, 8'h08);
        rd(WTC_CTRL_OFF, 8'h08, "ctrl_en");
        wr(WTC_CTRL_OFF, 8'h00);
        wr(WTC_CTRL_OFF, 8'h0b);
        rd(WTC_CTRL_OFF, 8'h08, "ctrl_locked");
        chk("en_locked", o_wd_enabled, 1'b1);
    endtask

    task automatic s_timed();
        wr(WTC_CTRL_OFF, 8'h18);
        rd(WTC_CTRL_OFF, 8'h18, "ctrl_open");
        wr(WTC_CTRL_OFF, 8'h05);
        rd(WTC_CTRL_OFF, 8'h05, "ctrl_commit");
        chk("en_off", o_wd_enabled, 1'b0);
        wr(WTC_CTRL_OFF, 8'h18);
        repeat (6) @(posedge i_clk);
        rd(WTC_CTRL_OFF, 8'h0d, "ctrl_ce_clear");
        wr(WTC_CTRL_OFF, 8'h00);
        rd(WTC_CTRL_OFF, 8'h0d, "ctrl_late");
        wr(WTC_CTRL_OFF, 8'h18);
        repeat (3) @(posedge i_clk);
        wr(WTC_CTRL_OFF, 8'h00);
        rd(WTC_CTRL_OFF, 8'h0d, "ctrl_edge");
    endtask

    task automatic s_prescale();
        for (int c = 0; c < 8; c++) begin
            wr(WTC_CTRL_OFF, 8'h18);
            wr(WTC_CTRL_OFF, 8'h08 | 8'(c));
            rd(WTC_CTRL_OFF, 8'h08 | 8'(c), "ctrl_psc");
            restart();
            ticks((BT << c) + 1, h);
            chk("timeout_tick", 16'(h), 16'(BT << c));
        end
        wr(WTC_CTRL_OFF, 8'h18);
        wr(WTC_CTRL_OFF, 8'h08);
        restart();
        ticks(BT - 1, h);
        restart();
        ticks(BT - 1, h);
        chk("restart_hold", 16'(h), 16'h0000);
        ticks(1, h);
        chk("restart_expire", 16'(h), 16'h0001);
        wr(WTC_CTRL_OFF, 8'h18);
        wr(WTC_CTRL_OFF, 8'h09);
        restart();
        ticks(2 * BT - 2, h);
        chk("short_hold", 16'(h), 16'h0000);
        wr(WTC_CTRL_OFF, 8'h18);
        wr(WTC_CTRL_OFF, 8'h08);
        ticks(1, h);
        chk("short_expire", 16'(h), 16'h0001);
        rd(WTC_STAT_OFF, 8'(1 << WTC_ST_TMO_BIT) | 8'(1 << WTC_ST_FUSE_BIT), "stat_tmo");
        rd(WTC_STAT_OFF, 8'(1 << WTC_ST_FUSE_BIT), "stat_clr");
    endtask

    task automatic s_level2();
        @(posedge i_clk);
        i_fuse_always_on <= 1'b1;
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (10) @(posedge i_clk);
        chk("lvl2_on", o_level2, 1'b1);
        rd(WTC_STAT_OFF, 8'(1 << WTC_ST_LVL2_BIT) | 8'(1 << WTC_ST_FUSE_BIT), "stat_l2");
        rd(WTC_CTRL_OFF, 8'h08, "ctrl_l2");
        wr(WTC_CTRL_OFF, 8'h18);
        wr(WTC_CTRL_OFF, 8'h00);
        rd(WTC_CTRL_OFF, 8'h08, "ctrl_l2_nodis");
        wr(WTC_CTRL_OFF, 8'h18);
        wr(WTC_CTRL_OFF, 8'h02);
        rd(WTC_CTRL_OFF, 8'h0a, "ctrl_l2_psc");
        chk("en_l2", o_wd_enabled, 1'b1);
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        s_reset_state();
        s_free_enable();
        s_timed();
        s_prescale();
        s_level2();
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
